/* det_dma_end_of_transfer.sv */
// module: end-of-transfer decision for the device dma path
`timescale 1ns/1ps

// Summary of operation
// - counter loads programmed byte count on rising edge of run enable
// - with count terminate enabled, counter zero ends transfer
// - with short packet terminate, short or empty packet on a non-isochronous endpoint sets transfer length
// - out: short or empty packet is moved first, then transfer stops
// - in: short packet stops transfer after all its bytes moved
// - in: counter zero mid-buffer yields short packet ending transfer
// - in: empty packet sent when buffer empty, short terminate set, counter zero
// - external end-of-transfer input ends transfer, any direction or type
// - clearing run enable ends any ongoing transfer
// - isochronous endpoint also ends on usb end-of-packet
// - sixteen-bit byte count register holds bytes per transfer
// - input stop on out discards active buffer, leaves inactive buffer
// - input stop on in sends partial packet at next in token
module det_dma_end_of_transfer
    import det_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic DMA_RUN_ENABLE_I,
    input wire logic COUNT_TERMINATE_ENABLE_I,
    input wire logic SHORT_PACKET_TERMINATE_I,
    input wire logic [15:0] BYTE_COUNT_I,
    input wire logic DIR_IN_I,
    input wire logic ISO_I,
    input wire logic WORD_MODE_I,
    input wire logic BUFFER_HAS_DATA_I,
    input wire logic SHORT_PKT_I,
    input wire logic BUFFER_EMPTIED_I,
    input wire logic USB_EOP_I,
    input wire logic END_TRANSFER_INPUT_I,
    input wire logic DMA_ACK_I,
    output logic DMA_REQ_O,
    output logic DMA_ACTIVE_O,
    output logic END_OF_TRANSFER_O,
    output logic DISCARD_ACTIVE_BUF_O,
    output logic SEND_PARTIAL_O,
    output logic SEND_EMPTY_O,
    output logic [15:0] COUNT_O
);

    // ***************************************
    // input synchronisers
    // ***************************************
    logic [2:0] eot_sync_reg;
    logic [2:0] eot_sync_next;
    logic eot_level_reg;
    logic eot_level_next;

    always_comb begin
        eot_sync_next = {eot_sync_reg[1:0], END_TRANSFER_INPUT_I};
        eot_level_next = eot_level_reg;
        if (eot_sync_reg[1] == eot_sync_reg[2]) begin
            eot_level_next = eot_sync_reg[2];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            eot_sync_reg <= SYNC_RESET;
            eot_level_reg <= 1'b0;
        end else begin
            eot_sync_reg <= eot_sync_next;
            eot_level_reg <= eot_level_next;
        end
    end

    // ***************************************
    // transfer control
    // ***************************************
    function automatic logic [15:0] step_bytes(input logic word);
        step_bytes = word ? BYTES_WORD : BYTES_BYTE;
    endfunction

    det_state_t state_reg;
    det_state_t state_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic en_prev_reg;
    logic eot_prev_reg;
    logic done_reg;
    logic done_next;
    logic discard_reg;
    logic discard_next;
    logic partial_reg;
    logic partial_next;
    logic empty_reg;
    logic empty_next;
    logic [15:0] step;
    logic [15:0] remain;
    logic ext_stop;
    logic en_rise;

    assign en_rise = DMA_RUN_ENABLE_I && !en_prev_reg;
    assign ext_stop = eot_level_reg && !eot_prev_reg;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        done_next = 1'b0;
        discard_next = 1'b0;
        partial_next = 1'b0;
        empty_next = 1'b0;
        step = step_bytes(WORD_MODE_I);
        remain = (count_reg > step) ? count_reg - step : CNT_RESET;
        unique case (state_reg)
            ST_IDLE: begin
                if (en_rise) begin
                    count_next = BYTE_COUNT_I;
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!DMA_RUN_ENABLE_I) begin
                    done_next = 1'b1;
                    state_next = ST_DONE;
                end else if (ext_stop) begin
                    done_next = 1'b1;
                    discard_next = !DIR_IN_I;
                    partial_next = DIR_IN_I;
                    state_next = ST_DONE;
                end else if (ISO_I && USB_EOP_I) begin
                    done_next = 1'b1;
                    state_next = ST_DONE;
                end else if (COUNT_TERMINATE_ENABLE_I && count_reg == CNT_RESET) begin
                    done_next = 1'b1;
                    partial_next = DIR_IN_I && BUFFER_HAS_DATA_I;
                    empty_next = DIR_IN_I && !BUFFER_HAS_DATA_I && SHORT_PACKET_TERMINATE_I;
                    state_next = ST_DONE;
                end else if (!ISO_I && SHORT_PACKET_TERMINATE_I && SHORT_PKT_I) begin
                    state_next = ST_DRAIN;
                end else if (DMA_ACK_I) begin
                    count_next = remain;
                end
            end
            ST_DRAIN: begin
                if (DMA_ACK_I) begin
                    count_next = remain;
                end
                if (!DMA_RUN_ENABLE_I || ext_stop || BUFFER_EMPTIED_I) begin
                    done_next = 1'b1;
                    discard_next = DMA_RUN_ENABLE_I && ext_stop && !DIR_IN_I;
                    partial_next = DMA_RUN_ENABLE_I && ext_stop && DIR_IN_I;
                    empty_next = DMA_RUN_ENABLE_I && !ext_stop && SHORT_PACKET_TERMINATE_I && DIR_IN_I
                        && !BUFFER_HAS_DATA_I && count_reg == CNT_RESET;
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!DMA_RUN_ENABLE_I) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            state_reg <= ST_IDLE;
            count_reg <= CNT_RESET;
            en_prev_reg <= 1'b0;
            eot_prev_reg <= 1'b0;
            done_reg <= 1'b0;
            discard_reg <= 1'b0;
            partial_reg <= 1'b0;
            empty_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            en_prev_reg <= DMA_RUN_ENABLE_I;
            eot_prev_reg <= eot_level_reg;
            done_reg <= done_next;
            discard_reg <= discard_next;
            partial_reg <= partial_next;
            empty_reg <= empty_next;
        end
    end

    assign DMA_ACTIVE_O = (state_reg == ST_RUN) || (state_reg == ST_DRAIN);
    assign DMA_REQ_O = DMA_ACTIVE_O && BUFFER_HAS_DATA_I;
    assign END_OF_TRANSFER_O = done_reg;
    assign DISCARD_ACTIVE_BUF_O = discard_reg;
    assign SEND_PARTIAL_O = partial_reg;
    assign SEND_EMPTY_O = empty_reg;
    assign COUNT_O = count_reg;

    // ***************************************
    // checks
    // ***************************************
    sequence s_run_rise;
        state_reg == ST_IDLE && DMA_RUN_ENABLE_I && !en_prev_reg;
    endsequence

    property p_load;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        s_run_rise |=> count_reg == $past(BYTE_COUNT_I);
    endproperty
    a_load: assert property (p_load) else $error("count not loaded");

    property p_zero;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_reg == ST_RUN && DMA_RUN_ENABLE_I && COUNT_TERMINATE_ENABLE_I && count_reg == 16'h0000)
        |=> END_OF_TRANSFER_O ##1 !DMA_ACTIVE_O;
    endproperty
    a_zero: assert property (p_zero) else $error("zero count did not end");

    property p_disable;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (DMA_ACTIVE_O && !DMA_RUN_ENABLE_I) |=> END_OF_TRANSFER_O && !DMA_ACTIVE_O;
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not end");

    property p_ext;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (DMA_ACTIVE_O && DMA_RUN_ENABLE_I && ext_stop) |=> END_OF_TRANSFER_O;
    endproperty
    a_ext: assert property (p_ext) else $error("input stop ignored");

    property p_discard;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        DISCARD_ACTIVE_BUF_O |-> END_OF_TRANSFER_O && !SEND_PARTIAL_O;
    endproperty
    a_discard: assert property (p_discard) else $error("discard without stop");

    property p_partial_ext;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_reg == ST_RUN && DMA_RUN_ENABLE_I && ext_stop && DIR_IN_I) |=> SEND_PARTIAL_O;
    endproperty
    a_partial_ext: assert property (p_partial_ext) else $error("partial not sent");

    property p_iso;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_reg == ST_RUN && DMA_RUN_ENABLE_I && ISO_I && USB_EOP_I) |=> END_OF_TRANSFER_O;
    endproperty
    a_iso: assert property (p_iso) else $error("eop ignored");

    property p_dec;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_reg == ST_RUN && state_next == ST_RUN && DMA_ACK_I && count_reg >= 16'h0002 && WORD_MODE_I)
        |=> count_reg == $past(count_reg) - 16'h0002;
    endproperty
    a_dec: assert property (p_dec) else $error("word decrement wrong");

    property p_drain;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_reg == ST_DRAIN && DMA_RUN_ENABLE_I && BUFFER_EMPTIED_I) |=> END_OF_TRANSFER_O ##1 !DMA_ACTIVE_O;
    endproperty
    a_drain: assert property (p_drain) else $error("short packet drain stuck");

    // run cycle with no higher-priority stop pending
    sequence s_run_clear;
        state_reg == ST_RUN && DMA_RUN_ENABLE_I && !ext_stop && !(ISO_I && USB_EOP_I);
    endsequence

    sequence s_zero_in;
        s_run_clear ##0 (COUNT_TERMINATE_ENABLE_I && count_reg == CNT_RESET && DIR_IN_I);
    endsequence

    property p_partial_zero;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        s_zero_in ##0 BUFFER_HAS_DATA_I |=> SEND_PARTIAL_O && !SEND_EMPTY_O;
    endproperty
    a_partial_zero: assert property (p_partial_zero) else $error("zero count sent no partial packet");

    property p_empty_zero;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        s_zero_in ##0 (!BUFFER_HAS_DATA_I && SHORT_PACKET_TERMINATE_I) |=> SEND_EMPTY_O && !SEND_PARTIAL_O;
    endproperty
    a_empty_zero: assert property (p_empty_zero) else $error("empty packet not sent");

    property p_short_hold;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        s_run_clear ##0 (!(COUNT_TERMINATE_ENABLE_I && count_reg == CNT_RESET) && !ISO_I
            && SHORT_PACKET_TERMINATE_I && SHORT_PKT_I) |=> DMA_ACTIVE_O && !END_OF_TRANSFER_O;
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("short packet stopped before drain");

    property p_eot_pulse;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        END_OF_TRANSFER_O |=> !END_OF_TRANSFER_O;
    endproperty
    a_eot_pulse: assert property (p_eot_pulse) else $error("end of transfer longer than one cycle");

    property p_eot_idle;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        END_OF_TRANSFER_O |-> !DMA_ACTIVE_O;
    endproperty
    a_eot_idle: assert property (p_eot_idle) else $error("still active at end of transfer");

    property p_byte_dec;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_reg == ST_RUN && state_next == ST_RUN && DMA_ACK_I && count_reg != CNT_RESET && !WORD_MODE_I)
        |=> count_reg == $past(count_reg) - 16'h0001;
    endproperty
    a_byte_dec: assert property (p_byte_dec) else $error("byte decrement wrong");

    property p_count_sat;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_reg == ST_RUN && state_next == ST_RUN && DMA_ACK_I && count_reg == 16'h0001 && WORD_MODE_I)
        |=> count_reg == CNT_RESET;
    endproperty
    a_count_sat: assert property (p_count_sat) else $error("word decrement wrapped");

    property p_discard_ext;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (DMA_ACTIVE_O && DMA_RUN_ENABLE_I && ext_stop && !DIR_IN_I) |=> DISCARD_ACTIVE_BUF_O && !SEND_PARTIAL_O;
    endproperty
    a_discard_ext: assert property (p_discard_ext) else $error("out stop kept buffer data");

    property p_done_hold;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        state_reg == ST_DONE |=> count_reg == $past(count_reg);
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("counter moved after stop");

endmodule

/* det_pkg.sv */
// package: constants and types for the dma end-of-transfer logic
package det_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [15:0] BYTES_BYTE = 16'h0001;
    localparam logic [15:0] BYTES_WORD = 16'h0002;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DRAIN,
        ST_DONE
    } det_state_t;
endpackage

/* det_dma_partner.sv */
// model of the fly-by dma controller on the far side
`timescale 1ns/1ps
module det_dma_partner (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic stop_i,
    output logic ack_o,
    output logic eot_o
);
    logic stop_seen = 1'b0;
    initial begin
        ack_o = 1'b0;
        eot_o = 1'b0;
    end
    // stop request taken away from the falling edge on which the bench drives it
    always @(posedge clk_i) begin
        stop_seen <= stop_i;
    end
    // one access per cycle while requested, random stalls
    always @(negedge clk_i) begin
        ack_o <= rst_n_i && req_i && ($urandom % 3 != 0);
        eot_o <= stop_seen;
    end
endmodule

/* det_dma_end_of_transfer_bench.sv */
// self-checking bench for the dma end-of-transfer block
`timescale 1ns/1ps
module det_dma_end_of_transfer_bench;
    import det_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, cen = 1'b0, spt = 1'b0;
    logic dir = 1'b0, iso = 1'b0, wm = 1'b0, data = 1'b0, sp = 1'b0;
    logic emp = 1'b0, eop = 1'b0, stop = 1'b0;
    logic ack, pin, req, act, end_transfer_input, disc, part, sempty;
    logic [15:0] bc = 16'h0000, cnt;
    logic [19:0] expq[$];
    logic [19:0] e;
    int mismatches = 0, samples_checked = 0, seen = 0;
    always #2 clk = ~clk;
    det_dma_end_of_transfer i_det_dma_end_of_transfer (.CLOCK_I(clk), .RESET_N_I(rst_n),
        .DMA_RUN_ENABLE_I(en), .COUNT_TERMINATE_ENABLE_I(cen), .SHORT_PACKET_TERMINATE_I(spt),
        .BYTE_COUNT_I(bc), .DIR_IN_I(dir), .ISO_I(iso), .WORD_MODE_I(wm), .BUFFER_HAS_DATA_I(data),
        .SHORT_PKT_I(sp), .BUFFER_EMPTIED_I(emp), .USB_EOP_I(eop), .END_TRANSFER_INPUT_I(pin),
        .DMA_ACK_I(ack), .DMA_REQ_O(req), .DMA_ACTIVE_O(act), .END_OF_TRANSFER_O(end_transfer_input),
        .DISCARD_ACTIVE_BUF_O(disc), .SEND_PARTIAL_O(part), .SEND_EMPTY_O(sempty), .COUNT_O(cnt));
    det_dma_partner i_det_dma_partner (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .stop_i(stop),
        .ack_o(ack), .eot_o(pin));
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
        samples_checked++;
        if (x !== y) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, x, y);
        end
    endtask
    task automatic chk_bit(input string n, input logic x, input logic y);
        samples_checked++;
        if (x !== y) begin
            mismatches++;
            $display("mismatch %s exp %b got %b", n, x, y);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watcher: each end-of-transfer pulse consumes the oldest note
    always @(negedge clk) begin
        if (end_transfer_input === 1'b1) begin
            seen++;
            chk_bit("active_at_eot", 1'b0, act);
            if (expq.size() == 0) begin
                chk("spurious_eot", 16'h0000, 16'h0001);
            end else begin
                e = expq.pop_front();
                chk("flags", {13'h0000, e[18:16]}, {13'h0000, disc, part, sempty});
                if (e[19]) chk("count", e[15:0], cnt);
            end
        end
    end
    // kind: 0 count zero, 1 pin, 2 enable low, 3 eop, 4 short packet
    task automatic run(input logic d, i, w, c, s, h, input int k, input logic [15:0] n,
        input logic [2:0] f);
        int t;
        int s0;
        {dir, iso, wm, cen, spt, data, bc} = {d, i, w, c, s, h, n};
        s0 = seen;
        expq.push_back({k != 2, f, (k == 0) ? 16'h0000 : n});
        @(negedge clk) en = 1'b1;
        @(negedge clk);
        chk_bit("active", 1'b1, act);
        chk_bit("request", h, req);
        case (k)
            1: stop = 1'b1;
            2: en = 1'b0;
            3: eop = 1'b1;
            4: sp = 1'b1;
            default: ;
        endcase
        // the pin filter needs the stop held for at least two cycles
        if (k == 1) begin
            repeat (2) @(negedge clk);
        end
        @(negedge clk) {stop, eop, sp} = 3'b000;
        if (k == 4) begin
            repeat (2) @(negedge clk);
            emp = 1'b1;
            @(negedge clk) emp = 1'b0;
        end
        for (t = 0; t < 200 && seen == s0; t++) @(negedge clk);
        if (seen == s0) begin
            chk("timeout", 16'h0000, 16'h0001);
            final_report();
        end
        en = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    initial begin
        void'($urandom(32'h1070));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int r = 0; r < 4; r++) begin
            run(r[0], 0, r[1], 1, 0, 1, 0, 16'($urandom_range(40, 1)), {1'b0, r[0], 1'b0});
            run(r[0], r[0] & r[1], 0, 0, 0, 0, 1, 16'($urandom), {~r[0], r[0], 1'b0});
        end
        run(1, 0, 0, 1, 1, 0, 0, 16'h0000, 3'b001);
        run(0, 0, 0, 0, 0, 1, 2, 16'($urandom), 3'b000);
        run(0, 1, 0, 0, 0, 0, 3, 16'($urandom), 3'b000);
        run(0, 0, 0, 0, 1, 0, 4, 16'($urandom), 3'b000);
        run(1, 0, 0, 0, 1, 0, 4, 16'($urandom), 3'b000);
        // reset in mid-transfer returns to idle with a cleared counter
        {dir, iso, wm, cen, spt, data, bc} = {6'b000001, 16'($urandom)};
        @(negedge clk) en = 1'b1;
        repeat (2) @(negedge clk);
        chk_bit("active_before_reset", 1'b1, act);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk_bit("active_in_reset", 1'b0, act);
        chk("count_in_reset", 16'h0000, cnt);
        en = 1'b0;
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk_bit("active_after_reset", 1'b0, act);
        final_report();
    end
endmodule
